// ==== common/gmq_defines.svh ====
// gmq_defines.svh: offsets, field positions, reset values and counts
// assumes: included by bare name from the design and verification modules
`ifndef GMQ_DEFINES_SVH
`define GMQ_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define GMQ_OFF_B_QUAL 12'h000
`define GMQ_OFF_D_MUX 12'h004
`define GMQ_OFF_D_DIR 12'h008
`define GMQ_OFF_D_QUAL 12'h00c
`define GMQ_OFF_E_MUX 12'h010
`define GMQ_OFF_E_DIR 12'h014
`define GMQ_OFF_E_QUAL 12'h018

// ****************************************
// fields and reset values
// ****************************************
`define GMQ_PER_MSB 7
`define GMQ_PER_LSB 0
`define GMQ_REG_RST 16'h0000
`define GMQ_PER_RST 8'h00
`define GMQ_D_IMPL 16'h0063
`define GMQ_E_IMPL 16'h0007

// ****************************************
// counts
// ****************************************
`define GMQ_QUAL_SAMPLES 3

`endif

// ==== common/gmq_pkg.sv ====
// gmq_pkg: types shared by the pin mux and input qualifier
// assumes: constants come from gmq_defines.svh
package gmq_pkg;

    // ****************************************
    // register select
    // ****************************************
    typedef enum logic [2:0] {
        GMQ_SEL_B_QUAL = 3'b000,
        GMQ_SEL_D_MUX = 3'b001,
        GMQ_SEL_D_DIR = 3'b010,
        GMQ_SEL_D_QUAL = 3'b011,
        GMQ_SEL_E_MUX = 3'b100,
        GMQ_SEL_E_DIR = 3'b101,
        GMQ_SEL_E_QUAL = 3'b110,
        GMQ_SEL_NONE = 3'b111
    } gmq_reg_sel_t;

    // ****************************************
    // peripheral input bundles
    // ****************************************
    typedef struct packed {
        logic timer1_trip_or_drive_protect_a;
        logic timer2_compare_trip;
        logic timer3_trip_or_drive_protect_b;
        logic timer4_compare_trip;
    } gmq_trip_t;

    typedef struct packed {
        logic ext_irq1_or_branch_input;
        logic ext_irq2_or_conversion_start;
        logic ext_nmi_or_irq13;
    } gmq_xint_t;

endpackage

// ==== logic/gmq_sample_tick.sv ====
// gmq_sample_tick: sampling strobe every 2N clocks for one port
// assumes: period comes from a register on the same clock
`timescale 1ns/1ps
module gmq_sample_tick (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] period_i,
    output logic tick_o,
    output logic bypass_o
);
    logic [8:0] cnt_q;
    logic [8:0] lim;

    assign lim = {period_i, 1'b0} - 9'h001;
    assign bypass_o = (period_i == 8'h00);

    // ****************************************
    // period counter
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || bypass_o)
        begin
            cnt_q <= 9'h000;
            tick_o <= 1'b0;
        end
        else if (cnt_q >= lim)
        begin
            cnt_q <= 9'h000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 9'h001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ==== logic/gmq_qualifier.sv ====
// gmq_qualifier: two-flop sync and sample-window qualifier per pin
// assumes: pins are asynchronous; tick and bypass from gmq_sample_tick
`timescale 1ns/1ps
`include "gmq_defines.svh"
module gmq_qualifier #(
    parameter int WIDTH = 16,
    parameter logic [15:0] IMPL = 16'hffff,
    parameter int SAMPLES = `GMQ_QUAL_SAMPLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic tick_i,
    input wire logic bypass_i,
    output logic [WIDTH-1:0] qual_o
);
    // ****************************************
    // per-bit qualifier
    // ****************************************
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        if (IMPL[i])
        begin : g_impl
            logic s1_q;
            logic s2_q;
            logic out_q;
            logic [SAMPLES-1:0] hist_q;

            assign qual_o[i] = out_q;

            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end
                else
                begin
                    s1_q <= pin_i[i];
                    s2_q <= s1_q;
                end
            end

            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    hist_q <= '0;
                    out_q <= 1'b0;
                end
                else if (bypass_i)
                begin
                    hist_q <= {SAMPLES{s2_q}};
                    out_q <= s2_q; // RULE_01
                end
                else if (tick_i)
                begin
                    hist_q <= {hist_q[SAMPLES-2:0], s2_q};
                    if (hist_q[SAMPLES-2:0] == {(SAMPLES-1){s2_q}})
                    begin
                        out_q <= s2_q; // RULE_09
                    end
                end
            end

            qual_stable_a: assert property ( // RULE_09
                @(posedge clk_sys_i) disable iff (rst_i)
                ($changed(qual_o[i]) && !$past(bypass_i))
                    |-> (hist_q == {SAMPLES{qual_o[i]}}))
                else $error("qualified input changed without stable samples");
        end
        else
        begin : g_rsvd
            assign qual_o[i] = 1'b0;
        end
    end
endmodule

// ==== logic/gmq_gpio_mux_qual.sv ====
// gmq_gpio_mux_qual: pin function mux and input qualification, ports d and e
// assumes: apb master on clk_sys_i; protected_write_enable_i from the cpu
// on the same clock; pins are asynchronous
//
// Summary of operation
// RULE_01: period zero: only synchronize, no filtering
// RULE_02: period n samples every 2n clocks
// RULE_03: period bits 7-0, upper bits read zero
// RULE_04: protected registers written only with enable
// RULE_05: port d mux one routes trip inputs
// RULE_06: port e mux one routes interrupt inputs
// RULE_07: unimplemented mux and direction bits read zero
// RULE_08: ports d and e use type-1 qualification
// RULE_09: value changes after consecutive equal samples
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "gmq_defines.svh"
module gmq_gpio_mux_qual (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic protected_write_enable_i,
    input wire logic [15:0] port_d_pin_i,
    input wire logic [15:0] port_e_pin_i,
    output logic [15:0] port_d_pin_oe_o,
    output logic [15:0] port_e_pin_oe_o,
    output logic [15:0] port_d_gpio_data_o,
    output logic [15:0] port_e_gpio_data_o,
    output gmq_pkg::gmq_trip_t trip_o,
    output gmq_pkg::gmq_xint_t xint_o,
    output logic [7:0] port_b_sample_period_o
);
    // ****************************************
    // declarations
    // ****************************************
    gmq_pkg::gmq_reg_sel_t sel;
    logic wr_en;
    logic rd_setup;
    logic [15:0] b_qual_q;
    logic [15:0] d_mux_q;
    logic [15:0] d_dir_q;
    logic [15:0] d_qual_q;
    logic [15:0] e_mux_q;
    logic [15:0] e_dir_q;
    logic [15:0] e_qual_q;
    logic [15:0] wr16;
    logic [15:0] rd_val;
    logic d_tick;
    logic d_bypass;
    logic e_tick;
    logic e_bypass;
    logic [15:0] d_qual;
    logic [15:0] e_qual;

    // ****************************************
    // apb decode
    // ****************************************
    always_comb
    begin
        case (paddr_i)
            `GMQ_OFF_B_QUAL: sel = gmq_pkg::GMQ_SEL_B_QUAL;
            `GMQ_OFF_D_MUX: sel = gmq_pkg::GMQ_SEL_D_MUX;
            `GMQ_OFF_D_DIR: sel = gmq_pkg::GMQ_SEL_D_DIR;
            `GMQ_OFF_D_QUAL: sel = gmq_pkg::GMQ_SEL_D_QUAL;
            `GMQ_OFF_E_MUX: sel = gmq_pkg::GMQ_SEL_E_MUX;
            `GMQ_OFF_E_DIR: sel = gmq_pkg::GMQ_SEL_E_DIR;
            `GMQ_OFF_E_QUAL: sel = gmq_pkg::GMQ_SEL_E_QUAL;
            default: sel = gmq_pkg::GMQ_SEL_NONE;
        endcase
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && (sel == gmq_pkg::GMQ_SEL_NONE);
    assign wr_en = psel_i && penable_i && pwrite_i && protected_write_enable_i; // RULE_04
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign wr16 = pwdata_i[15:0];

    // ****************************************
    // protected registers
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            b_qual_q <= `GMQ_REG_RST;
            d_qual_q <= `GMQ_REG_RST;
            e_qual_q <= `GMQ_REG_RST;
        end
        else if (wr_en)
        begin
            case (sel)
                gmq_pkg::GMQ_SEL_B_QUAL: b_qual_q <= {8'h00, wr16[`GMQ_PER_MSB:`GMQ_PER_LSB]}; // RULE_03
                gmq_pkg::GMQ_SEL_D_QUAL: d_qual_q <= {8'h00, wr16[`GMQ_PER_MSB:`GMQ_PER_LSB]}; // RULE_03
                gmq_pkg::GMQ_SEL_E_QUAL: e_qual_q <= {8'h00, wr16[`GMQ_PER_MSB:`GMQ_PER_LSB]}; // RULE_03
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            d_mux_q <= `GMQ_REG_RST; // RULE_05
            d_dir_q <= `GMQ_REG_RST;
            e_mux_q <= `GMQ_REG_RST;
            e_dir_q <= `GMQ_REG_RST;
        end
        else if (wr_en)
        begin
            case (sel)
                gmq_pkg::GMQ_SEL_D_MUX: d_mux_q <= wr16 & `GMQ_D_IMPL; // RULE_07
                gmq_pkg::GMQ_SEL_D_DIR: d_dir_q <= wr16 & `GMQ_D_IMPL; // RULE_07
                gmq_pkg::GMQ_SEL_E_MUX: e_mux_q <= wr16 & `GMQ_E_IMPL; // RULE_07
                gmq_pkg::GMQ_SEL_E_DIR: e_dir_q <= wr16 & `GMQ_E_IMPL; // RULE_07
                default:
                begin
                end
            endcase
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb
    begin
        case (sel)
            gmq_pkg::GMQ_SEL_B_QUAL: rd_val = b_qual_q;
            gmq_pkg::GMQ_SEL_D_MUX: rd_val = d_mux_q;
            gmq_pkg::GMQ_SEL_D_DIR: rd_val = d_dir_q;
            gmq_pkg::GMQ_SEL_D_QUAL: rd_val = d_qual_q;
            gmq_pkg::GMQ_SEL_E_MUX: rd_val = e_mux_q;
            gmq_pkg::GMQ_SEL_E_DIR: rd_val = e_dir_q;
            gmq_pkg::GMQ_SEL_E_QUAL: rd_val = e_qual_q;
            default: rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            prdata_o <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            prdata_o <= {16'h0000, rd_val};
        end
    end

    assign port_b_sample_period_o = b_qual_q[`GMQ_PER_MSB:`GMQ_PER_LSB];

    // ****************************************
    // qualification
    // ****************************************
    gmq_sample_tick u_d_tick (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .period_i(d_qual_q[`GMQ_PER_MSB:`GMQ_PER_LSB]), // RULE_02
        .tick_o(d_tick),
        .bypass_o(d_bypass)
    );

    gmq_sample_tick u_e_tick (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .period_i(e_qual_q[`GMQ_PER_MSB:`GMQ_PER_LSB]), // RULE_02
        .tick_o(e_tick),
        .bypass_o(e_bypass)
    );

    gmq_qualifier #(
        .WIDTH(16),
        .IMPL(`GMQ_D_IMPL),
        .SAMPLES(`GMQ_QUAL_SAMPLES)
    ) u_d_qual (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(port_d_pin_i),
        .tick_i(d_tick), // RULE_08
        .bypass_i(d_bypass),
        .qual_o(d_qual)
    );

    gmq_qualifier #(
        .WIDTH(16),
        .IMPL(`GMQ_E_IMPL),
        .SAMPLES(`GMQ_QUAL_SAMPLES)
    ) u_e_qual (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(port_e_pin_i),
        .tick_i(e_tick), // RULE_08
        .bypass_i(e_bypass),
        .qual_o(e_qual)
    );

    // ****************************************
    // function routing
    // ****************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            trip_o <= '1;
            xint_o <= '1;
        end
        else
        begin
            // idle high when the pin is a plain gpio
            trip_o.timer1_trip_or_drive_protect_a <= d_mux_q[0] ? d_qual[0] : 1'b1; // RULE_05
            trip_o.timer2_compare_trip <= d_mux_q[1] ? d_qual[1] : 1'b1; // RULE_05
            trip_o.timer3_trip_or_drive_protect_b <= d_mux_q[5] ? d_qual[5] : 1'b1; // RULE_05
            trip_o.timer4_compare_trip <= d_mux_q[6] ? d_qual[6] : 1'b1; // RULE_05
            xint_o.ext_irq1_or_branch_input <= e_mux_q[0] ? e_qual[0] : 1'b1; // RULE_06
            xint_o.ext_irq2_or_conversion_start <= e_mux_q[1] ? e_qual[1] : 1'b1; // RULE_06
            xint_o.ext_nmi_or_irq13 <= e_mux_q[2] ? e_qual[2] : 1'b1; // RULE_06
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            port_d_pin_oe_o <= 16'h0000;
            port_e_pin_oe_o <= 16'h0000;
            port_d_gpio_data_o <= 16'h0000;
            port_e_gpio_data_o <= 16'h0000;
        end
        else
        begin
            port_d_pin_oe_o <= d_dir_q & ~d_mux_q;
            port_e_pin_oe_o <= e_dir_q & ~e_mux_q;
            port_d_gpio_data_o <= d_qual & ~d_mux_q;
            port_e_gpio_data_o <= e_qual & ~e_mux_q;
        end
    end

    // ****************************************
    // assertion helpers
    // ****************************************
    logic [8:0] gap_q;
    logic stab_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            gap_q <= 9'h000;
            stab_q <= 1'b0;
        end
        else
        begin
            gap_q <= d_tick ? 9'h000 : gap_q + 9'h001;
            if (wr_en && sel == gmq_pkg::GMQ_SEL_D_QUAL)
            begin
                stab_q <= 1'b0;
            end
            else if (d_tick)
            begin
                stab_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    bypass_sync_a: assert property ( // RULE_01
        @(posedge clk_sys_i) disable iff (rst_i)
        (d_bypass && !d_mux_q[0])[*4]
            |-> port_d_gpio_data_o[0] == $past(port_d_pin_i[0], 4))
        else $error("bypassed input is not the synchronized pin");

    tick_period_a: assert property ( // RULE_02
        @(posedge clk_sys_i) disable iff (rst_i)
        (d_tick && stab_q) |-> gap_q == ({1'b0, d_qual_q[7:0]} << 1) - 9'h001)
        else $error("sampling period is not twice the field");

    qual_read_a: assert property ( // RULE_03
        @(posedge clk_sys_i) disable iff (rst_i)
        (psel_i && penable_i && !pwrite_i && sel == gmq_pkg::GMQ_SEL_D_QUAL)
            |-> prdata_o[31:8] == 24'h000000 && prdata_o[7:0] == d_qual_q[7:0])
        else $error("qualification register read wrong");

    protect_write_a: assert property ( // RULE_04
        @(posedge clk_sys_i) disable iff (rst_i)
        (psel_i && penable_i && pwrite_i && !protected_write_enable_i)
            |=> $stable(d_mux_q) && $stable(e_mux_q) && $stable(d_dir_q) && $stable(e_dir_q)
                && $stable(d_qual_q) && $stable(e_qual_q) && $stable(b_qual_q))
        else $error("protected register written without enable");

    trip_route_a: assert property ( // RULE_05
        @(posedge clk_sys_i) disable iff (rst_i)
        ##1 trip_o.timer3_trip_or_drive_protect_b
            == ($past(d_mux_q[5]) ? $past(d_qual[5]) : 1'b1))
        else $error("trip input routing wrong");

    xint_route_a: assert property ( // RULE_06
        @(posedge clk_sys_i) disable iff (rst_i)
        ##1 xint_o.ext_nmi_or_irq13 == ($past(e_mux_q[2]) ? $past(e_qual[2]) : 1'b1))
        else $error("interrupt input routing wrong");

    rsvd_zero_a: assert property ( // RULE_07
        @(posedge clk_sys_i) disable iff (rst_i)
        (d_mux_q & ~`GMQ_D_IMPL) == 16'h0000 && (d_dir_q & ~`GMQ_D_IMPL) == 16'h0000
            && (e_mux_q & ~`GMQ_E_IMPL) == 16'h0000 && (e_dir_q & ~`GMQ_E_IMPL) == 16'h0000)
        else $error("reserved mux or direction bit set");

    qual_on_tick_a: assert property ( // RULE_08
        @(posedge clk_sys_i) disable iff (rst_i)
        ($changed(d_qual) && !$past(d_bypass)) |-> $past(d_tick))
        else $error("qualified port d input changed off the sampling tick");

    // ****************************************
    // covers
    // ****************************************
    trip_seen_c: cover property (
        @(posedge clk_sys_i) disable iff (rst_i)
        d_mux_q[0] && $fell(trip_o.timer1_trip_or_drive_protect_a));

    qual_change_c: cover property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !d_bypass && $changed(d_qual[1]));

    locked_write_c: cover property (
        @(posedge clk_sys_i) disable iff (rst_i)
        psel_i && penable_i && pwrite_i && !protected_write_enable_i);
endmodule

// ==== verification/gmq_pin_model.sv ====
// gmq_pin_model: the pins of ports d and e as the outside world drives them
// assumes: levels are requested on clk_sys_i; unbonded pins float and wander
`timescale 1ns/1ps
`include "gmq_defines.svh"
module gmq_pin_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] d_level_i,
    input wire logic [15:0] e_level_i,
    output logic [15:0] port_d_pin_o,
    output logic [15:0] port_e_pin_o
);
    // ****************************************
    // pin drive, reserved pins change every cycle
    // ****************************************
    logic [15:0] spin_q = 16'h5a5a;
    initial port_d_pin_o = 16'h0000;
    initial port_e_pin_o = 16'h0000;
    always @(posedge clk_sys_i)
    begin
        spin_q <= ~spin_q;
        port_d_pin_o <= (d_level_i & `GMQ_D_IMPL) | (spin_q & ~`GMQ_D_IMPL);
        port_e_pin_o <= (e_level_i & `GMQ_E_IMPL) | (spin_q & ~`GMQ_E_IMPL);
    end
endmodule

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the pin mux and input qualifier
// assumes: apb slave at byte offsets of gmq_defines.svh; pins from gmq_pin_model
`timescale 1ns/1ps
`include "gmq_defines.svh"
module tb_top;
    // ****************************************
    // signals
    // ****************************************
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic wen = 1'b0;
    logic [15:0] lvl_d = 16'h0000;
    logic [15:0] lvl_e = 16'h0000;
    logic [15:0] d_pin, e_pin, d_oe, e_oe, d_dat, e_dat;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, obs;
    logic [7:0] b_per;
    gmq_pkg::gmq_trip_t trip_o;
    gmq_pkg::gmq_xint_t xint_o;
    logic [32:0] exp_q[$];
    logic [31:0] wr [7];
    logic [15:0] msk [7] = '{16'h00ff, 16'h0063, 16'h0063, 16'h00ff, 16'h0007, 16'h0007, 16'h00ff};
    int failures = 0;
    int checked = 0;
    int sel = 0;
    int per, i, k, z;
    always #4 clk_sys_i = ~clk_sys_i;
    assign obs = (sel == 0) ? d_dat[0] : (sel == 1) ? trip_o[3] : xint_o[2];

    gmq_gpio_mux_qual gmq_gpio_mux_qual_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .protected_write_enable_i(wen), .port_d_pin_i(d_pin), .port_e_pin_i(e_pin),
        .port_d_pin_oe_o(d_oe), .port_e_pin_oe_o(e_oe), .port_d_gpio_data_o(d_dat),
        .port_e_gpio_data_o(e_dat), .trip_o(trip_o), .xint_o(xint_o),
        .port_b_sample_period_o(b_per));
    gmq_pin_model gmq_pin_model_inst (.clk_sys_i(clk_sys_i), .d_level_i(lvl_d),
        .e_level_i(lvl_e), .port_d_pin_o(d_pin), .port_e_pin_o(e_pin));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
        end
        while (pready_o !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic measure(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        lvl_d[0] <= v;
        lvl_e[0] <= v;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (obs !== v && n <= hi);
        check({32'h0, 1'(n >= lo && n <= hi)}, 33'h1);
    endtask

    // ****************************************
    // result monitor
    // ****************************************
    always @(posedge clk_sys_i)
    begin
        if (psel && penable && pready_o === 1'b1)
            check({pslverr_o, pwrite ? 32'h0 : prdata_o}, exp_q.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        test_done();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        per = $urandom(32'hce23e11b);
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        lvl_d <= 16'($urandom()) & 16'hfffe;
        repeat (2) @(posedge clk_sys_i);
        check({29'h0, trip_o}, 33'hf);
        check({30'h0, xint_o}, 33'h7);
        for (i = 0; i < 7; i++)
            apb(1'b0, 12'(i * 4), 32'h0, 33'h0);
        apb(1'b1, `GMQ_OFF_D_MUX, 32'hffff, 33'h0);
        apb(1'b0, `GMQ_OFF_D_MUX, 32'h0, 33'h0);
        wen <= 1'b1;
        for (i = 0; i < 7; i++)
        begin
            wr[i] = $urandom();
            apb(1'b1, 12'(i * 4), wr[i], 33'h0);
        end
        for (i = 0; i < 7; i++)
            apb(1'b0, 12'(i * 4), 32'h0, {17'h0, wr[i][15:0] & msk[i]});
        apb(1'b1, 12'h01c, $urandom(), 33'h100000000);
        apb(1'b0, 12'h01c, 32'h0, 33'h100000000);
        check({25'h0, b_per}, {25'h0, wr[0][7:0]});
        apb(1'b1, `GMQ_OFF_D_DIR, 32'hffff, 33'h0);
        apb(1'b1, `GMQ_OFF_D_MUX, 32'h0003, 33'h0);
        apb(1'b1, `GMQ_OFF_E_DIR, 32'hffff, 33'h0);
        apb(1'b1, `GMQ_OFF_E_MUX, 32'h0001, 33'h0);
        repeat (2) @(posedge clk_sys_i);
        check({17'h0, d_oe}, 33'h0060);
        check({17'h0, e_oe}, 33'h0006);
        apb(1'b1, `GMQ_OFF_D_MUX, 32'h0, 33'h0);
        for (k = 0; k < 3; k++)
        begin
            per = (k == 0) ? 0 : (k == 1) ? 1 : $urandom_range(8, 2);
            apb(1'b1, `GMQ_OFF_D_QUAL, per, 33'h0);
            measure(1'b0, 0, 6 * per + 10);
            measure(1'b1, (per == 0) ? 2 : 4 * per, (per == 0) ? 6 : 6 * per + 8);
            lvl_d[0] <= 1'b0;
            @(posedge clk_sys_i);
            lvl_d[0] <= 1'b1;
            z = 0;
            repeat (8 * per + 8)
            begin
                @(posedge clk_sys_i);
                z += (obs !== 1'b1);
            end
            check({1'b0, 32'(z)}, {1'b0, 32'((per == 0) ? 1 : 0)});
        end
        check({17'h0, d_dat}, {17'h0, lvl_d & 16'h0063});
        apb(1'b1, `GMQ_OFF_D_MUX, 32'h0063, 33'h0);
        sel = 1;
        measure(1'b0, 0, 6 * per + 10);
        measure(1'b1, 4 * per, 6 * per + 8);
        check({29'h0, trip_o}, {29'h0, lvl_d[0], lvl_d[1], lvl_d[5], lvl_d[6]});
        check({17'h0, d_dat}, 33'h0);
        apb(1'b1, `GMQ_OFF_E_QUAL, 32'h0, 33'h0);
        apb(1'b1, `GMQ_OFF_E_MUX, 32'h0007, 33'h0);
        sel = 2;
        measure(1'b0, 2, 6);
        measure(1'b1, 2, 6);
        check({30'h0, xint_o}, {30'h0, lvl_e[0], lvl_e[1], lvl_e[2]});
        check({17'h0, e_dat}, 33'h0);
        test_done();
    end
endmodule
